//--- core/cpwm_top.sv
// Two configurable open-drain outputs with register port and sensor tracking.
// Assumes register strobes and sensor words are synchronous to core_clk.
module cpwm_top
    import cpwm_pkg::*;
#(
    parameter bit TRACK_SUPPORTED = 1'b1,
    parameter int unsigned CYC_100HZ = CYC_PER_US * T_100HZ_US,
    parameter int unsigned CYC_10HZ = CYC_PER_US * T_10HZ_US,
    parameter int unsigned CYC_1HZ = CYC_PER_US * T_1HZ_US,
    parameter int unsigned CYC_0P1HZ = CYC_PER_US * T_0P1HZ_US,
    parameter int unsigned CYC_50HZ = CYC_PER_US * T_50HZ_US,
    parameter int unsigned CYC_WMIN = CYC_PER_US * T_SRV_WIDE_MIN_US,
    parameter int unsigned CYC_WMAX = CYC_PER_US * T_SRV_WIDE_MAX_US,
    parameter int unsigned CYC_NMIN = CYC_PER_US * T_SRV_NARROW_MIN_US,
    parameter int unsigned CYC_NMAX = CYC_PER_US * T_SRV_NARROW_MAX_US
) (
    input wire logic core_clk, // Core clock
    input wire logic srst, // Synchronous reset
    input wire logic [15:0] reg_addr, // Register address
    input wire logic [15:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [15:0] reg_rdata, // Read data, cycle after strobe
    input wire logic [15:0] sensor_0, // Sensor reading 0
    input wire logic [15:0] sensor_1, // Sensor reading 1
    input wire logic [15:0] sensor_2, // Sensor reading 2
    input wire logic [15:0] sensor_3, // Sensor reading 3
    output logic pin0_out, // Output 0 drive level
    output logic pin0_oe, // Output 0 enable
    output logic pin1_out, // Output 1 drive level
    output logic pin1_oe // Output 1 enable
);


    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    typedef enum logic [1:0] {SC_PICK, SC_DIV, SC_STORE} cpwm_scst_t;

    logic [15:0] cfg [2];
    logic [15:0] val [2];
    logic [15:0] lo [2];
    logic [15:0] hi [2];
    logic [6:0] trk [2];
    logic [15:0] sens [4];
    logic [1:0] map_on;
    logic [6:0] eff_pct [2];
    logic [15:0] rd_mux;
    logic [1:0] wr_cfg;
    logic [1:0] wr_val;
    logic [1:0] wr_lo;
    logic [1:0] wr_hi;
    cpwm_scst_t sc_st;
    logic sc_ch;
    logic [22:0] sc_num;
    logic [22:0] sc_dsh;
    logic [6:0] sc_q;
    logic [2:0] sc_bit;
    logic [15:0] sc_s;
    logic [15:0] sc_lo;
    logic [15:0] sc_hi;
    logic [15:0] pick_s;
    logic [15:0] pick_lo;
    logic [15:0] pick_hi;

    // Saturate a written value to full scale before it reaches the generator
    function automatic logic [6:0] clamp_pct(input logic [15:0] v);
        clamp_pct = (v > 16'(PCT_FULL)) ? PCT_FULL : v[6:0];
    endfunction

    // Tracking is honoured only when the hardware supports it
    function automatic logic tracked(input logic [15:0] c);
        tracked = TRACK_SUPPORTED && c[F_SRC_EN];
    endfunction

    // Configuration word as software sees it, with the read-only bit merged
    function automatic logic [15:0] cfg_view(input logic [15:0] c);
        cfg_view = (c & CFG_WMASK) | (16'(TRACK_SUPPORTED) << F_MAPOK);
    endfunction

    assign sens[0] = sensor_0;
    assign sens[1] = sensor_1;
    assign sens[2] = sensor_2;
    assign sens[3] = sensor_3;

    // Write decode; only two outputs have configuration words
    assign wr_cfg[0] = reg_wr && (reg_addr == OFS_CFG0);
    assign wr_cfg[1] = reg_wr && (reg_addr == OFS_CFG1);
    assign wr_val[0] = reg_wr && (reg_addr == OFS_VAL0);
    assign wr_val[1] = reg_wr && (reg_addr == OFS_VAL1);
    assign wr_lo[0] = reg_wr && (reg_addr == OFS_LO0);
    assign wr_lo[1] = reg_wr && (reg_addr == OFS_LO1);
    assign wr_hi[0] = reg_wr && (reg_addr == OFS_HI0);
    assign wr_hi[1] = reg_wr && (reg_addr == OFS_HI1);

    // Percent that drives each generator
    assign map_on[0] = tracked(cfg[0]);
    assign map_on[1] = tracked(cfg[1]);
    assign eff_pct[0] = map_on[0] ? trk[0] : clamp_pct(val[0]);
    assign eff_pct[1] = map_on[1] ? trk[1] : clamp_pct(val[1]);

    // Read mux; a tracked value reads back the tracked percent
    assign rd_mux =
        (reg_addr == OFS_CFG0) ? cfg_view(cfg[0]) :
        (reg_addr == OFS_CFG1) ? cfg_view(cfg[1]) :
        (reg_addr == OFS_VAL0) ? (map_on[0] ? 16'(trk[0]) : val[0]) :
        (reg_addr == OFS_VAL1) ? (map_on[1] ? 16'(trk[1]) : val[1]) :
        (reg_addr == OFS_LO0) ? lo[0] :
        (reg_addr == OFS_HI0) ? hi[0] :
        (reg_addr == OFS_LO1) ? lo[1] :
        (reg_addr == OFS_HI1) ? hi[1] : 16'h0000;

    // Register file; writes to the read-only and reserved bits are dropped
    always_ff @(posedge core_clk) begin
        if (srst) begin
            for (int i = 0; i < 2; i++) begin
                cfg[i] <= CFG_RST;
                val[i] <= VAL_RST;
                lo[i] <= LO_RST;
                hi[i] <= HI_RST;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (wr_cfg[i]) cfg[i] <= reg_wdata & CFG_WMASK;
                if (wr_val[i]) val[i] <= reg_wdata;
                if (wr_lo[i]) lo[i] <= reg_wdata;
                if (wr_hi[i]) hi[i] <= reg_wdata;
            end
        end
    end

    // Read data appears in the cycle after the strobe only
    always_ff @(posedge core_clk) begin
        if (srst) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 16'h0000;
        end
    end

    // Scaler inputs for the channel whose turn it is
    assign pick_s = sens[cfg[sc_ch][F_SRC_LSB +: 2]];
    assign pick_lo = lo[sc_ch];
    assign pick_hi = hi[sc_ch];

    // Shared scaler: clamp at the limits, else (s-lo)*100/(hi-lo) by 7-step
    // restoring division. One divider serves both channels in turn, trading
    // a few dozen cycles of tracking lag for area.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sc_st <= SC_PICK;
            sc_ch <= 1'b0;
            sc_num <= 23'h0;
            sc_dsh <= 23'h0;
            sc_q <= 7'h00;
            sc_bit <= 3'h0;
            sc_s <= 16'h0000;
            sc_lo <= 16'h0000;
            sc_hi <= 16'h0000;
            trk[0] <= 7'h00;
            trk[1] <= 7'h00;
        end else begin
            case (sc_st)
                SC_PICK: begin
                    sc_s <= pick_s;
                    sc_lo <= pick_lo;
                    sc_hi <= pick_hi;
                    if (pick_s <= pick_lo) begin
                        sc_q <= 7'h00;
                        sc_st <= SC_STORE;
                    end else if (pick_s >= pick_hi) begin
                        sc_q <= PCT_FULL;
                        sc_st <= SC_STORE;
                    end else begin
                        sc_num <= 23'(pick_s - pick_lo) * 23'(PCT_STEPS);
                        sc_dsh <= {1'b0, pick_hi - pick_lo, 6'h00};
                        sc_q <= 7'h00;
                        sc_bit <= 3'h6;
                        sc_st <= SC_DIV;
                    end
                end
                SC_DIV: begin
                    if (sc_num >= sc_dsh) begin
                        sc_num <= sc_num - sc_dsh;
                        sc_q[sc_bit] <= 1'b1;
                    end
                    sc_dsh <= sc_dsh >> 1;
                    sc_bit <= sc_bit - 3'h1;
                    if (sc_bit == 3'h0) sc_st <= SC_STORE;
                end
                SC_STORE: begin
                    trk[sc_ch] <= sc_q;
                    sc_ch <= ~sc_ch;
                    sc_st <= SC_PICK;
                end
                default: begin
                    sc_st <= SC_PICK;
                end
            endcase
        end
    end

    // Output generators; type decode lives in the channel
    cpwm_chan #(
        .CYC_100HZ(CYC_100HZ),
        .CYC_10HZ(CYC_10HZ),
        .CYC_1HZ(CYC_1HZ),
        .CYC_0P1HZ(CYC_0P1HZ),
        .CYC_50HZ(CYC_50HZ),
        .CYC_WMIN(CYC_WMIN),
        .CYC_WMAX(CYC_WMAX),
        .CYC_NMIN(CYC_NMIN),
        .CYC_NMAX(CYC_NMAX)
    ) u_chan0 (
        .core_clk(core_clk),
        .srst(srst),
        .otype(cfg[0][F_TYPE_LSB +: 3]),
        .rate(cfg[0][F_RATE_LSB +: 3]),
        .pol(cfg[0][F_POL]),
        .span(cfg[0][F_SPAN]),
        .pct(eff_pct[0]),
        .pin_oe(pin0_oe)
    );

    cpwm_chan #(
        .CYC_100HZ(CYC_100HZ),
        .CYC_10HZ(CYC_10HZ),
        .CYC_1HZ(CYC_1HZ),
        .CYC_0P1HZ(CYC_0P1HZ),
        .CYC_50HZ(CYC_50HZ),
        .CYC_WMIN(CYC_WMIN),
        .CYC_WMAX(CYC_WMAX),
        .CYC_NMIN(CYC_NMIN),
        .CYC_NMAX(CYC_NMAX)
    ) u_chan1 (
        .core_clk(core_clk),
        .srst(srst),
        .otype(cfg[1][F_TYPE_LSB +: 3]),
        .rate(cfg[1][F_RATE_LSB +: 3]),
        .pol(cfg[1][F_POL]),
        .span(cfg[1][F_SPAN]),
        .pct(eff_pct[1]),
        .pin_oe(pin1_oe)
    );

    // Open-drain pins only ever pull low; the level flop stays at zero
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pin0_out <= 1'b0;
            pin1_out <= 1'b0;
        end else begin
            pin0_out <= 1'b0;
            pin1_out <= 1'b0;
        end
    end

    a_cfg_readback: assert property ((reg_rd && reg_addr == OFS_CFG1) |=>
        reg_rdata == ((cfg[1] & CFG_WMASK) | (16'(TRACK_SUPPORTED) << F_MAPOK)))
        else $error("configuration readback wrong");
    a_value_echo: assert property ((reg_wr && reg_addr == OFS_VAL0 && !map_on[0])
        ##1 (reg_rd && reg_addr == OFS_VAL0 && !map_on[0]) |=> reg_rdata == $past(reg_wdata, 2))
        else $error("untracked value not echoed");
    a_pol_reset: assert property ($past(srst) |-> !cfg[0][F_POL] && !cfg[1][F_POL])
        else $error("polarity not reset to active low");
    a_track_low: assert property ((sc_st == SC_STORE && sc_s <= sc_lo) |-> sc_q == 7'h00)
        else $error("reading at low limit not zero");
    a_track_high: assert property ((sc_st == SC_STORE && sc_s >= sc_hi && sc_s > sc_lo)
        |-> sc_q == PCT_FULL)
        else $error("reading at high limit not full");
    a_untracked_pct: assert property ((!map_on[0] && val[0] <= 16'(PCT_FULL))
        |-> eff_pct[0] == val[0][6:0])
        else $error("untracked percent not passed through");
    a_track_ignored: assert property (!TRACK_SUPPORTED |-> eff_pct[1] == clamp_pct(val[1]))
        else $error("source select not ignored");

endmodule // cpwm_top

//--- shared/cpwm_pkg.sv
// Shared constants for the configurable PWM / servo output block.
// Assumes a single 200 MHz core clock and a plain strobe register port.
package cpwm_pkg;

    // Clock rate and time base
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned US_PER_S = 1_000_000;
    localparam int unsigned CYC_PER_US = CLK_HZ / US_PER_S;

    // Repetition periods in microseconds
    localparam int unsigned T_100HZ_US = 10_000;
    localparam int unsigned T_10HZ_US = 100_000;
    localparam int unsigned T_1HZ_US = 1_000_000;
    localparam int unsigned T_0P1HZ_US = 10_000_000;
    localparam int unsigned T_50HZ_US = 20_000;

    // Servo pulse limits in microseconds
    localparam int unsigned T_SRV_WIDE_MIN_US = 500;
    localparam int unsigned T_SRV_WIDE_MAX_US = 2_500;
    localparam int unsigned T_SRV_NARROW_MIN_US = 1_000;
    localparam int unsigned T_SRV_NARROW_MAX_US = 2_000;

    // Full scale of the percentage value
    localparam logic [6:0] PCT_FULL = 7'h64;
    localparam int unsigned PCT_STEPS = 100;

    // Register offsets
    localparam logic [15:0] OFS_VAL0 = 16'h00F0;
    localparam logic [15:0] OFS_VAL1 = 16'h00F4;
    localparam logic [15:0] OFS_CFG0 = 16'h0124;
    localparam logic [15:0] OFS_CFG1 = 16'h0126;
    localparam logic [15:0] OFS_LO0 = 16'h03E0;
    localparam logic [15:0] OFS_HI0 = 16'h03E4;
    localparam logic [15:0] OFS_LO1 = 16'h03E8;
    localparam logic [15:0] OFS_HI1 = 16'h03EC;

    // Configuration field positions
    localparam int F_RATE_LSB = 0;
    localparam int F_POL = 3;
    localparam int F_SPAN = 4;
    localparam int F_TYPE_LSB = 8;
    localparam int F_MAPOK = 12;
    localparam int F_SRC_LSB = 13;
    localparam int F_SRC_EN = 15;
    localparam logic [15:0] CFG_WMASK = 16'hE71F;

    // Reset values
    localparam logic [15:0] CFG_RST = 16'h0000;
    localparam logic [15:0] VAL_RST = 16'h0000;
    localparam logic [15:0] LO_RST = 16'h0000;
    localparam logic [15:0] HI_RST = 16'hFFFF;

    // Output type and rate codes
    localparam logic [2:0] OT_NULL = 3'h0;
    localparam logic [2:0] OT_ONOFF = 3'h1;
    localparam logic [2:0] OT_PWM = 3'h2;
    localparam logic [2:0] OT_SERVO = 3'h3;
    localparam logic [2:0] RATE_100HZ = 3'h0;
    localparam logic [2:0] RATE_10HZ = 3'h1;
    localparam logic [2:0] RATE_1HZ = 3'h2;
    localparam logic [2:0] RATE_0P1HZ = 3'h3;
    localparam logic [2:0] RATE_50HZ = 3'h4;

endpackage

//--- core/cpwm_chan.sv
// One output channel: frame counter, pulse width and open-drain pin enable.
// Assumes type, rate and percent arrive from registers on the core clock.
module cpwm_chan
    import cpwm_pkg::*;
#(
    parameter int unsigned CYC_100HZ = CYC_PER_US * T_100HZ_US,
    parameter int unsigned CYC_10HZ = CYC_PER_US * T_10HZ_US,
    parameter int unsigned CYC_1HZ = CYC_PER_US * T_1HZ_US,
    parameter int unsigned CYC_0P1HZ = CYC_PER_US * T_0P1HZ_US,
    parameter int unsigned CYC_50HZ = CYC_PER_US * T_50HZ_US,
    parameter int unsigned CYC_WMIN = CYC_PER_US * T_SRV_WIDE_MIN_US,
    parameter int unsigned CYC_WMAX = CYC_PER_US * T_SRV_WIDE_MAX_US,
    parameter int unsigned CYC_NMIN = CYC_PER_US * T_SRV_NARROW_MIN_US,
    parameter int unsigned CYC_NMAX = CYC_PER_US * T_SRV_NARROW_MAX_US
) (
    input wire logic core_clk, // Core clock
    input wire logic srst, // Synchronous reset
    input wire logic [2:0] otype, // Output type
    input wire logic [2:0] rate, // Rate code
    input wire logic pol, // Active state
    input wire logic span, // Servo span select
    input wire logic [6:0] pct, // Effective percent
    output logic pin_oe // Pin pulled low when high
);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    // Spans kept whole; dividing after the product avoids a zero step on short spans
    localparam logic [31:0] WSPAN = 32'(CYC_WMAX - CYC_WMIN);
    localparam logic [31:0] NSPAN = 32'(CYC_NMAX - CYC_NMIN);

    logic [31:0] cnt;
    logic [31:0] hi_lat;
    logic [31:0] period;
    logic [31:0] pwm_step;
    logic [31:0] next_hi;
    logic wrap;
    logic active;

    // Frame length: servo knows only the 100 Hz and 50 Hz frames
    assign period = (otype == OT_SERVO) ?
        ((rate == RATE_50HZ) ? 32'(CYC_50HZ) : 32'(CYC_100HZ)) :
        (rate == RATE_10HZ) ? 32'(CYC_10HZ) :
        (rate == RATE_1HZ) ? 32'(CYC_1HZ) :
        (rate == RATE_0P1HZ) ? 32'(CYC_0P1HZ) : 32'(CYC_100HZ);
    assign pwm_step = period / PCT_STEPS;

    // Width of the next pulse, latched only at frame end to avoid runt pulses
    assign next_hi = (otype == OT_SERVO) ?
        (span ? 32'(CYC_WMIN) + (32'(pct) * WSPAN) / PCT_STEPS
              : 32'(CYC_NMIN) + (32'(pct) * NSPAN) / PCT_STEPS) :
        32'(pct) * pwm_step;
    assign wrap = (cnt >= period - 32'h1);
    assign active = (otype == OT_ONOFF) ? (pct != 7'h00) :
        ((otype == OT_PWM) || (otype == OT_SERVO)) && (cnt < hi_lat);

    // Frame counter, idle outside the timed modes
    always_ff @(posedge core_clk) begin
        if (srst || (otype != OT_PWM && otype != OT_SERVO)) begin
            cnt <= 32'h0;
            hi_lat <= 32'h0;
        end else if (wrap) begin
            cnt <= 32'h0;
            hi_lat <= next_hi;
        end else begin
            cnt <= cnt + 32'h1;
        end
    end

    // Open-drain drive: active high releases the pin, active low pulls it
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pin_oe <= 1'b0;
        end else begin
            pin_oe <= (otype != OT_NULL) && (active ^ pol);
        end
    end

    a_null_floats: assert property (otype == OT_NULL |=> !pin_oe)
        else $error("null output drives the pin");
    a_onoff_level: assert property ((otype == OT_ONOFF && pct != 7'h00) |=> pin_oe == !$past(pol))
        else $error("on/off level wrong");
    a_pwm_wrap: assert property ((otype == OT_PWM && cnt == period - 32'h1 && $stable(otype))
        |=> cnt == 32'h0)
        else $error("frame counter did not wrap");
    a_servo_frame: assert property ((otype == OT_SERVO && rate == RATE_50HZ)
        |-> period == 32'(CYC_50HZ))
        else $error("servo 50 Hz frame wrong");
    a_servo_bounds: assert property ((otype == OT_SERVO && wrap && $stable(otype)) |=>
        hi_lat >= (span ? 32'(CYC_WMIN) : 32'(CYC_NMIN)) &&
        hi_lat <= (span ? 32'(CYC_WMAX) : 32'(CYC_NMAX)))
        else $error("servo pulse outside span");

endmodule // cpwm_chan

//--- verif/cpwm_load.sv
// Pull-up load on one open-drain output; measures the last low and high run.
// Assumes the pin enable and drive level change only on core_clk.
module cpwm_load (
    input wire logic core_clk, // Core clock
    input wire logic pin_out, // Drive level from the block
    input wire logic pin_oe, // Drive enable from the block
    output logic level, // Resolved wire level
    output int low_len, // Last completed low run in cycles
    output int high_len // Last completed high run in cycles
);
    timeunit 1ns;
    timeprecision 1ps;
    int run;
    logic prev;
    // The pull-up wins whenever the block lets go of the wire
    assign level = pin_oe ? pin_out : 1'b1;
    initial begin
        run = 0;
        prev = 1'b1;
        low_len = 0;
        high_len = 0;
    end
    // A run is stored only when it ends, so a stuck wire keeps old lengths
    always @(posedge core_clk) begin
        if (level !== prev) begin
            if (prev) high_len = run;
            else low_len = run;
            run = 1;
        end else begin
            run = run + 1;
        end
        prev = level;
    end
endmodule // cpwm_load

//--- verif/test_configurable_pwm_servo_output.sv
// Self-checking bench for the two-output PWM / servo block.
// Assumes shortened frame counts and a pull-up load on each output.
module test_configurable_pwm_servo_output;
    import cpwm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic [15:0] reg_addr = 16'h0000;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [15:0] sensor_0 = 16'h1388;
    logic [15:0] sensor_1 = 16'h0000;
    logic [15:0] sensor_2 = 16'h1388;
    logic [15:0] sensor_3 = 16'h1388;
    logic pin0_out, pin0_oe, pin1_out, pin1_oe, lv0, lv1;
    int lo0, hi0, lo1, hi1;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int per [4] = '{200, 400, 800, 1600};

    cpwm_top #(.CYC_100HZ(200), .CYC_10HZ(400), .CYC_1HZ(800), .CYC_0P1HZ(1600),
        .CYC_50HZ(400), .CYC_WMIN(10), .CYC_WMAX(50), .CYC_NMIN(20), .CYC_NMAX(40))
    i_cpwm_top (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sensor_0(sensor_0), .sensor_1(sensor_1), .sensor_2(sensor_2),
        .sensor_3(sensor_3), .pin0_out(pin0_out), .pin0_oe(pin0_oe),
        .pin1_out(pin1_out), .pin1_oe(pin1_oe));
    cpwm_load i_cpwm_load_0 (.core_clk(core_clk), .pin_out(pin0_out), .pin_oe(pin0_oe),
        .level(lv0), .low_len(lo0), .high_len(hi0));
    cpwm_load i_cpwm_load_1 (.core_clk(core_clk), .pin_out(pin1_out), .pin_oe(pin1_oe),
        .level(lv1), .low_len(lo1), .high_len(hi1));

    // Clock and a hang guard well above the expected run length
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fail_count = fail_count + 1;
            give_verdict();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("mismatch %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input string name, input logic [15:0] a, input logic [15:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(name, {16'h0000, e}, {16'h0000, reg_rdata});
    endtask

    task automatic t_reset();
        chk("oe0 at reset", 0, pin0_oe);
        rd_chk("cfg0 reset", OFS_CFG0, 16'h1000);
        rd_chk("val0 reset", OFS_VAL0, VAL_RST);
        rd_chk("hi0 reset", OFS_HI0, HI_RST);
        rd_chk("unmapped", 16'h0200, 16'h0000);
        wr_reg(OFS_CFG1, 16'h0000);
        rd_chk("cfg1 ro bit", OFS_CFG1, 16'h1000);
    endtask

    // PWM at every rate with a lopsided duty; pol 0 pulls low while active
    task automatic t_pwm();
        int lo;
        wr_reg(OFS_VAL0, 16'h001E);
        for (int r = 0; r < 4; r++) begin
            wr_reg(OFS_CFG0, 16'h0200 | 16'(r));
            repeat (3 * per[r]) @(posedge core_clk);
            lo = 30 * (per[r] / 100);
            chk("pwm low", lo, lo0);
            chk("pwm high", per[r] - lo, hi0);
        end
    endtask

    // Servo on the second output: both frames, both spans, both ends
    task automatic t_servo();
        int fr, mn, mx, w;
        for (int k = 0; k < 8; k++) begin
            fr = k[0] ? 400 : 200;
            mn = k[1] ? 10 : 20;
            mx = k[1] ? 50 : 40;
            w = k[2] ? mx : mn;
            wr_reg(OFS_VAL1, k[2] ? 16'h0064 : 16'h0000);
            wr_reg(OFS_CFG1, 16'h0300 | (k[1] ? 16'h0010 : 16'h0) | (k[0] ? 16'h4 : 16'h0));
            repeat (3 * fr) @(posedge core_clk);
            chk("servo pulse", w, lo1);
            chk("servo frame", fr - w, hi1);
        end
    endtask

    task automatic t_onoff();
        wr_reg(OFS_VAL0, 16'h0007);
        wr_reg(OFS_CFG0, 16'h0103);
        repeat (20) @(posedge core_clk);
        chk("onoff active low", 0, lv0);
        wr_reg(OFS_CFG0, 16'h0111);
        repeat (500) @(posedge core_clk);
        chk("onoff rate span", 0, lv0);
        chk("onoff steady", 1, pin0_oe);
        wr_reg(OFS_CFG0, 16'h0119);
        repeat (20) @(posedge core_clk);
        chk("active high", 1, lv0);
        wr_reg(OFS_VAL0, 16'h0000);
        repeat (20) @(posedge core_clk);
        chk("inactive high", 0, lv0);
        wr_reg(OFS_CFG0, 16'h0018);
        repeat (20) @(posedge core_clk);
        chk("null released", 0, pin0_oe);
    endtask

    // Tracking: all four sensors carry the same reading while each source is selected in turn
    task automatic t_track();
        logic [15:0] s [4] = '{16'd1500, 16'd1250, 16'd900, 16'd2100};
        logic [15:0] e [4] = '{16'd50, 16'd25, 16'd0, 16'd100};
        wr_reg(OFS_LO0, 16'h03E8);
        wr_reg(OFS_HI0, 16'h07D0);
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            sensor_0 <= s[i];
            sensor_1 <= s[i];
            sensor_2 <= s[i];
            sensor_3 <= s[i];
            wr_reg(OFS_CFG0, 16'h8200 | 16'(i << 13));
            repeat (40) @(posedge core_clk);
            rd_chk("tracked pct", OFS_VAL0, e[i]);
        end
        repeat (600) @(posedge core_clk);
        chk("tracked duty", 0, lv0);
        wr_reg(OFS_CFG0, 16'h0200);
        wr_reg(OFS_VAL0, 16'h0025);
        rd_chk("untracked pct", OFS_VAL0, 16'h0025);
        wr_reg(OFS_HI1, 16'h0064);
        wr_reg(OFS_CFG1, 16'hE310);
        repeat (40) @(posedge core_clk);
        rd_chk("tracked sensor", OFS_VAL1, 16'h0064);
        repeat (600) @(posedge core_clk);
        chk("tracked servo max", 50, lo1);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        t_reset();
        t_pwm();
        t_servo();
        t_onoff();
        t_track();
        give_verdict();
    end
endmodule // test_configurable_pwm_servo_output
